// file: twi_defines.svh
// Register offsets, field positions, reset values and widths for the
// two-wire master controller. Definitions only; included by bare name.
`ifndef TWI_DEFINES_SVH
`define TWI_DEFINES_SVH

// Byte offsets of the register words
`define OFS_MODE 8'h00
`define OFS_STATE 8'h04
`define OFS_DATA 8'h08
`define OFS_LOW 8'h0C
`define OFS_HIGH 8'h10
`define OFS_HOLD 8'h14
`define OFS_OWN 8'h18

// Mode register fields
`define MODE_EN 0
`define MODE_START 1
`define MODE_STOP 2
`define MODE_ACKNOWLEDGE_ENABLE 3
`define MODE_IRQ 4

// Reset values
`define RST_LOW 8'h40
`define RST_HIGH 8'h40
`define RST_HOLD 8'h20
`define RST_OWN 7'h00
`define RST_DATA 8'h00

// Timing widths
`define PERIOD_W 8
`define BITS_PER_BYTE 4'h8

`endif

// file: twi_pkg.sv
// Types shared by the two-wire controller files.
// Assumes the constants header is included where numbers are needed.
package twi_pkg;

   // Controller sequencing
   typedef enum logic [4:0] {
      ST_IDLE, ST_START, ST_RS_LOW, ST_RS_RISE, ST_BIT_LOW, ST_BIT_RISE,
      ST_BIT_HIGH, ST_HOLD, ST_STOP_LOW, ST_STOP_RISE, ST_STOP_HIGH,
      ST_STOP_DONE, ST_LISTEN, ST_SL_FALL, ST_SL_ACK, ST_SL_ACK_HI, ST_SL_HOLD
   } st_t;

   // Captured AHB address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } ahb_req_t;

   // Status word, bit 0 upward: lost, mastership, byte done, stop, slave, ack, busy
   typedef struct packed {
      logic busy;
      logic rxack;
      logic slsel;
      logic stopev;
      logic bdone;
      logic mship;
      logic lost;
   } status_t;

   // One-cycle bus event pulses
   typedef struct packed {
      logic slsel;
      logic stopev;
      logic bdone;
      logic mship;
      logic lost;
   } ev_t;

   // Synchronised line levels
   typedef struct packed {
      logic scl;
      logic sda;
   } lines_t;

endpackage : twi_pkg

// file: line_sync.sv
// Two-flop synchroniser, one pair per bit.
// Assumes inputs are asynchronous to sys_clk; only the second stage reads the first.
`timescale 1ns/1ns
module line_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Lines
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_r;
         // First stage feeds only the second
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               meta_r <= 1'b1;
               sync_out[i] <= 1'b1;
            end
            else
            begin
               meta_r <= async_in[i];
               sync_out[i] <= meta_r;
            end
         end
      end
   endgenerate

endmodule : line_sync

// file: twi_master.sv
// Two-wire bus controller: master transmitter with arbitration, clock
// stretching and busy tracking, registers reached over AHB-Lite.
// Assumes external pull-ups; pins are open drain, driven low when *_oe is high.
`timescale 1ns/1ns
`include "twi_defines.svh"

module twi_master
   import twi_pkg::*;
#(
   parameter int CW = `PERIOD_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Bus lines, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Status
   output logic irq_flag,
   output logic bus_busy
);

   import twi_pkg::*;

   ahb_req_t req_r;
   lines_t lines_s;
   lines_t lines_q;
   st_t state_r;
   ev_t ev_r;
   status_t status;
   logic peripheral_enable;
   logic start_r;
   logic stop_r;
   logic acknowledge_enable;
   logic [7:0] shift_data_reg;
   logic [CW-1:0] clock_low_period_reg;
   logic [CW-1:0] clock_high_period_reg;
   logic [CW-1:0] data_hold_delay_reg;
   logic [6:0] own_slave_address_reg;
   logic [CW-1:0] cnt_r;
   logic [3:0] bit_idx_r;
   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;
   logic addr_ph_r;
   logic rxack_r;
   logic arbitration_lost;
   logic mastership_event;
   logic byte_done_event;
   logic stop_event;
   logic slave_sel;
   logic busy_r;
   logic wr_mode;
   logic wr_state;
   logic scl_fall;
   logic scl_rise;
   logic start_det;
   logic stop_det;
   logic take_start;
   logic take_stop;
   logic low_done;
   logic high_done;

   // Pins pass two flops before anything looks at them
   line_sync #(
      .W(2)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in({scl_in, sda_in}),
      .sync_out(lines_s)
   );

   // Previous synchronised levels for edge finding
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         lines_q <= '1;
      else
         lines_q <= lines_s;
   end

   // Edges and bus conditions
   assign scl_fall = lines_q.scl & ~lines_s.scl;
   assign scl_rise = ~lines_q.scl & lines_s.scl;
   assign start_det = lines_s.scl & lines_q.scl & lines_q.sda & ~lines_s.sda;
   assign stop_det = lines_s.scl & lines_q.scl & ~lines_q.sda & lines_s.sda;

   // Busy from START until STOP, repeated START changes nothing
   always_ff @(posedge sys_clk)
   begin
      if (rst || !peripheral_enable)
         busy_r <= 1'b0;
      else if (start_det)
         busy_r <= 1'b1;
      else if (stop_det)
         busy_r <= 1'b0;
   end

   // AHB address phase capture; always zero wait, always OKAY
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         req_r <= '0;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         req_r.valid <= hsel & htrans[1] & hready;
         req_r.write <= hwrite;
         req_r.addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign wr_mode = req_r.valid & req_r.write & (req_r.addr == `OFS_MODE);
   assign wr_state = req_r.valid & req_r.write & (req_r.addr == `OFS_STATE);

   // Read data registered at the address phase, unmapped reads give zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (hsel & htrans[1] & hready & ~hwrite)
      begin
         case (haddr[7:0])
            `OFS_MODE: hrdata <= {27'h0, irq_flag, acknowledge_enable, stop_r,
                                  start_r, peripheral_enable};
            `OFS_STATE: hrdata <= {25'h0, status};
            `OFS_DATA: hrdata <= {24'h0, shift_data_reg};
            `OFS_LOW: hrdata <= 32'(clock_low_period_reg);
            `OFS_HIGH: hrdata <= 32'(clock_high_period_reg);
            `OFS_HOLD: hrdata <= 32'(data_hold_delay_reg);
            `OFS_OWN: hrdata <= {25'h0, own_slave_address_reg};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Start taken from idle on a free bus, or from a held stage
   assign take_start = start_r & ((state_r == ST_IDLE & ~busy_r) |
                                  (state_r == ST_HOLD & wr_state));
   assign take_stop = stop_r & ~start_r & (state_r == ST_HOLD) & wr_state;

   // Software registers; start and stop clear once acted on
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         peripheral_enable <= 1'b0;
         start_r <= 1'b0;
         stop_r <= 1'b0;
         acknowledge_enable <= 1'b0;
         shift_data_reg <= `RST_DATA;
         clock_low_period_reg <= CW'(`RST_LOW);
         clock_high_period_reg <= CW'(`RST_HIGH);
         data_hold_delay_reg <= CW'(`RST_HOLD);
         own_slave_address_reg <= `RST_OWN;
      end
      else
      begin
         if (take_start)
            start_r <= 1'b0;
         if (take_stop)
            stop_r <= 1'b0;
         if (wr_mode)
         begin
            peripheral_enable <= hwdata[`MODE_EN];
            start_r <= hwdata[`MODE_START];
            stop_r <= hwdata[`MODE_STOP];
            acknowledge_enable <= hwdata[`MODE_ACKNOWLEDGE_ENABLE];
         end
         if (req_r.valid & req_r.write)
         begin
            case (req_r.addr)
               `OFS_DATA: shift_data_reg <= hwdata[7:0];
               `OFS_LOW: clock_low_period_reg <= hwdata[CW-1:0];
               `OFS_HIGH: clock_high_period_reg <= hwdata[CW-1:0];
               `OFS_HOLD: data_hold_delay_reg <= hwdata[CW-1:0];
               `OFS_OWN: own_slave_address_reg <= hwdata[6:0];
               default: ;
            endcase
         end
      end
   end

   // Phase ends; hold point must be passed before the low phase ends
   assign low_done = (cnt_r >= clock_low_period_reg) & (cnt_r > data_hold_delay_reg);
   assign high_done = cnt_r >= clock_high_period_reg;

   // Bus sequencer: line drives, bit counting, shifting and event pulses
   always_ff @(posedge sys_clk)
   begin
      if (rst || !peripheral_enable)
      begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         bit_idx_r <= 4'h0;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         addr_ph_r <= 1'b0;
         rxack_r <= 1'b1;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         ev_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_r + 1'b1;
         ev_r <= '0;
         case (state_r)
            ST_IDLE:
            begin
               scl_oe <= 1'b0;
               sda_oe <= 1'b0;
               bit_idx_r <= 4'h0;
               if (take_start)
               begin
                  state_r <= ST_START;
                  sda_oe <= 1'b1;
                  tx_sh_r <= shift_data_reg;
                  addr_ph_r <= 1'b1;
                  cnt_r <= '0;
               end
            end
            ST_START:
               if (high_done)
               begin
                  state_r <= ST_BIT_LOW;
                  scl_oe <= 1'b1;
                  cnt_r <= '0;
               end
            ST_RS_LOW:
            begin
               if (cnt_r == data_hold_delay_reg)
                  sda_oe <= 1'b0;
               if (low_done)
               begin
                  scl_oe <= 1'b0;
                  state_r <= ST_RS_RISE;
               end
            end
            ST_RS_RISE:
               if (lines_s.scl)
               begin
                  state_r <= ST_START;
                  sda_oe <= 1'b1;
                  cnt_r <= '0;
               end
            ST_BIT_LOW:
            begin
               if (cnt_r == data_hold_delay_reg)
                  sda_oe <= (bit_idx_r == `BITS_PER_BYTE) ? 1'b0 : ~tx_sh_r[7];
               if (low_done)
               begin
                  scl_oe <= 1'b0;
                  state_r <= ST_BIT_RISE;
               end
            end
            ST_BIT_RISE:
               // Stretched clock: wait until SCL really rises
               if (lines_s.scl)
               begin
                  state_r <= ST_BIT_HIGH;
                  cnt_r <= '0;
                  rx_sh_r <= {rx_sh_r[6:0], lines_s.sda};
                  if (bit_idx_r == `BITS_PER_BYTE)
                     rxack_r <= lines_s.sda;
               end
            ST_BIT_HIGH:
            begin
               if (bit_idx_r != `BITS_PER_BYTE && !sda_oe && !lines_s.sda)
               begin
                  // Someone else drives low: stop driving at once
                  state_r <= addr_ph_r ? ST_LISTEN : ST_IDLE;
                  bit_idx_r <= bit_idx_r + 4'h1;
                  ev_r.lost <= 1'b1;
               end
               else if (high_done || scl_fall)
               begin
                  scl_oe <= 1'b1;
                  cnt_r <= '0;
                  tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                  if (bit_idx_r == `BITS_PER_BYTE)
                  begin
                     state_r <= ST_HOLD;
                     bit_idx_r <= 4'h0;
                     ev_r.mship <= addr_ph_r;
                     ev_r.bdone <= ~addr_ph_r;
                  end
                  else
                  begin
                     bit_idx_r <= bit_idx_r + 4'h1;
                     state_r <= ST_BIT_LOW;
                  end
               end
            end
            ST_HOLD:
            begin
               cnt_r <= '0;
               if (wr_state)
               begin
                  if (take_start)
                  begin
                     state_r <= ST_RS_LOW;
                     tx_sh_r <= shift_data_reg;
                     addr_ph_r <= 1'b1;
                  end
                  else if (take_stop)
                     state_r <= ST_STOP_LOW;
                  else
                  begin
                     state_r <= ST_BIT_LOW;
                     tx_sh_r <= shift_data_reg;
                     addr_ph_r <= 1'b0;
                  end
               end
            end
            ST_STOP_LOW:
            begin
               if (cnt_r == data_hold_delay_reg)
                  sda_oe <= 1'b1;
               if (low_done)
               begin
                  scl_oe <= 1'b0;
                  state_r <= ST_STOP_RISE;
               end
            end
            ST_STOP_RISE:
               if (lines_s.scl)
               begin
                  state_r <= ST_STOP_HIGH;
                  cnt_r <= '0;
               end
            ST_STOP_HIGH:
               if (high_done)
               begin
                  sda_oe <= 1'b0;
                  state_r <= ST_STOP_DONE;
               end
            ST_STOP_DONE:
            begin
               // Flag once our own STOP is seen, so status no longer reads busy
               if (stop_det)
                  ev_r.stopev <= 1'b1;
               if (wr_state && stop_event)
                  state_r <= ST_IDLE;
            end
            ST_LISTEN:
            begin
               // Passive: collect the rest of the address byte
               if (stop_det)
                  state_r <= ST_IDLE;
               else if (bit_idx_r == `BITS_PER_BYTE)
               begin
                  bit_idx_r <= 4'h0;
                  if (acknowledge_enable && rx_sh_r[7:1] == own_slave_address_reg)
                     state_r <= ST_SL_FALL;
                  else
                     state_r <= ST_IDLE;
               end
               else if (scl_rise)
               begin
                  rx_sh_r <= {rx_sh_r[6:0], lines_s.sda};
                  bit_idx_r <= bit_idx_r + 4'h1;
               end
            end
            ST_SL_FALL:
               if (scl_fall)
               begin
                  state_r <= ST_SL_ACK;
                  cnt_r <= '0;
               end
            ST_SL_ACK:
            begin
               if (cnt_r >= data_hold_delay_reg)
                  sda_oe <= 1'b1;
               if (scl_rise)
                  state_r <= ST_SL_ACK_HI;
            end
            ST_SL_ACK_HI:
               if (scl_fall)
               begin
                  sda_oe <= 1'b0;
                  scl_oe <= 1'b1;
                  ev_r.slsel <= 1'b1;
                  state_r <= ST_SL_HOLD;
               end
            ST_SL_HOLD:
               if (wr_state)
                  state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // Sticky status and flag; an event in the clearing cycle wins
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         arbitration_lost <= 1'b0;
         mastership_event <= 1'b0;
         byte_done_event <= 1'b0;
         stop_event <= 1'b0;
         slave_sel <= 1'b0;
         irq_flag <= 1'b0;
      end
      else
      begin
         arbitration_lost <= ev_r.lost | (arbitration_lost & ~wr_state);
         mastership_event <= ev_r.mship | (mastership_event & ~wr_state);
         byte_done_event <= ev_r.bdone | (byte_done_event & ~wr_state);
         stop_event <= ev_r.stopev | (stop_event & ~wr_state);
         slave_sel <= ev_r.slsel | (slave_sel & ~wr_state);
         irq_flag <= (|ev_r) | (irq_flag & ~wr_state);
      end
   end

   assign status = '{busy: busy_r, rxack: rxack_r, slsel: slave_sel,
                     stopev: stop_event, bdone: byte_done_event,
                     mship: mastership_event, lost: arbitration_lost};

   // Open-drain data always low; busy mirrored as a registered output
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         bus_busy <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         bus_busy <= busy_r;
      end
   end

endmodule : twi_master

// file: twi_master_assertions.sv
// Port-level checks on the two-wire controller.
// Assumes pulled-up open-drain lines and one AHB-Lite master.
`timescale 1ns/1ns
`include "twi_defines.svh"
module twi_master_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   // Lines and status
   input wire logic scl_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic irq_flag,
   input wire logic bus_busy
);
   logic wr_q;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Status write in its data phase; only then may the flag drop
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         wr_q <= 1'b0;
      else
         wr_q <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == `OFS_STATE;
   end
   // Pending flag holds itself and the clock line
   property p_irq_hold;
      irq_flag && !wr_q |=> irq_flag;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("flag dropped");
   property p_scl_hold;
      irq_flag && scl_oe && !wr_q |=> scl_oe;
   endproperty
   a_scl_hold: assert property (p_scl_hold)
      else $error("clock let go");
   property p_no_rise;
      irq_flag |=> !$rose(scl_oe);
   endproperty
   a_no_rise: assert property (p_no_rise)
      else $error("clock pulled while flagged");
   // Conditions made with SCL high move the busy state; only STOP raises the flag
   property p_start_busy;
      $rose(sda_oe) && scl_in && $past(scl_in) |-> ##[1:12] bus_busy;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("busy missing after start");
   property p_start_quiet;
      $rose(sda_oe) && scl_in && $past(scl_in) |=> !irq_flag [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet)
      else $error("flag after start");
   property p_stop_busy;
      $fell(sda_oe) && scl_in && $past(scl_in) |-> ##[1:12] !bus_busy;
   endproperty
   a_stop_busy: assert property (p_stop_busy)
      else $error("busy after stop");
   property p_stop_irq;
      $fell(sda_oe) && scl_in && $past(scl_in) |-> ##[1:600] irq_flag;
   endproperty
   a_stop_irq: assert property (p_stop_irq)
      else $error("no flag after stop");
   // High time counts only from a real rise, so a held line is waited out
   property p_stretch;
      $fell(scl_oe) ##1 !scl_in [*8] |-> !scl_oe;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("clock pulled while stretched");
endmodule : twi_master_assertions

bind twi_master twi_master_assertions chk_i (
   .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .scl_in(scl_in), .scl_oe(scl_oe),
   .sda_oe(sda_oe), .irq_flag(irq_flag), .bus_busy(bus_busy)
);

// file: twi_slave_model.sv
// Behavioural slave on the two-wire lines: shifts in, acks, stretches.
// Assumes pull-ups on both lines; a pull output high drives its line low.
`timescale 1ns/1ns
module twi_slave_model (
   // Lines
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull,
   // Control and capture
   input wire logic ack_en,
   input wire logic stretch_en,
   output logic [7:0] byte_q
);
   int cnt = 9;
   logic [7:0] sh = 8'h00;
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      byte_q = 8'h00;
   end
   // START or repeated START restarts the bit count
   always @(negedge sda)
      if (scl)
         cnt = -1;
   // Bits taken while SCL high, first one is the MSB
   always @(posedge scl)
      if (cnt >= 0 && cnt < 8)
         sh = {sh[6:0], sda};
   // SDA moves 20 ns into low so it never races the clock fall
   always @(negedge scl)
   begin
      cnt = cnt + 1;
      if (cnt == 4 && stretch_en)
      begin
         scl_pull = 1'b1;
         #200;
         scl_pull = 1'b0;
      end
      if (cnt == 8)
      begin
         byte_q = sh;
         #20 sda_pull = ack_en;
      end
      if (cnt == 9)
      begin
         cnt = 0;
         #20 sda_pull = 1'b0;
      end
   end
endmodule : twi_slave_model

// file: twi_master_tb.sv
// Bench: registers over AHB-Lite, then a full master write sequence.
// Assumes one slave model on pulled-up lines and a 250 MHz clock.
`timescale 1ns/1ns
`include "twi_defines.svh"
module twi_master_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, scl_oe, sda_oe, irq_flag, bus_busy, s_scl, s_sda;
   logic ack_en = 1'b1;
   logic str_en = 1'b1;
   logic [7:0] got;
   logic [7:0] ofs [7] = '{`OFS_MODE, `OFS_STATE, `OFS_DATA, `OFS_LOW, `OFS_HIGH, `OFS_HOLD, 8'h1C};
   logic [7:0] rv [7] = '{8'h00, 8'h20, `RST_DATA, `RST_LOW, `RST_HIGH, `RST_HOLD, 8'h00};
   int errors = 0;
   int samples_checked = 0;
   // Wired-AND lines with pull-ups
   wire logic scl = !(scl_oe || s_scl);
   wire logic sda = !(sda_oe || s_sda);
   always #2 sys_clk = ~sys_clk;
   twi_master dut (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .scl_in(scl), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .irq_flag(irq_flag), .bus_busy(bus_busy)
   );
   twi_slave_model slv (
      .scl(scl), .sda(sda), .scl_pull(s_scl), .sda_pull(s_sda),
      .ack_en(ack_en), .stretch_en(str_en), .byte_q(got)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One single word transfer; held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge sys_clk);
      while (hreadyout !== 1'b1)
         @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1)
         @(posedge sys_clk);
      rd = hrdata;
   endtask : bus
   // Load data and mode, release a held clock, await the next event
   task automatic step(input logic [7:0] d, input logic [7:0] m, input logic [7:0] exp);
      int n;
      n = 0;
      bus(1'b1, `OFS_DATA, {24'h0, d});
      bus(1'b1, `OFS_MODE, {24'h0, m});
      if (irq_flag === 1'b1)
         bus(1'b1, `OFS_STATE, 32'h0);
      @(posedge sys_clk);
      chk(irq_flag, 1'b0);
      while (irq_flag !== 1'b1 && n < 5000)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk(irq_flag, 1'b1);
      bus(1'b0, `OFS_STATE, 32'h0);
      chk(rd, {24'h0, exp});
   endtask : step
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // Whole sequence needs about 2500 ns
   initial
   begin
      #100000;
      errors++;
      final_report;
   end
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      foreach (ofs[i])
      begin
         bus(1'b0, ofs[i], 32'h0);
         chk(rd, {24'h0, rv[i]});
      end
      $display("test reset values done");
      // Seven low plus ten high cycles: a 68 ns link clock
      bus(1'b1, `OFS_LOW, 32'h06);
      bus(1'b1, `OFS_HIGH, 32'h06);
      bus(1'b1, `OFS_HOLD, 32'h03);
      step(8'hA4, 8'h03, 8'h42);
      chk(got, 8'hA4);
      chk(scl_oe, 1'b1);
      chk(bus_busy, 1'b1);
      bus(1'b0, `OFS_MODE, 32'h0);
      chk(rd, 32'h11);
      str_en <= 1'b0;
      step(8'h3C, 8'h01, 8'h44);
      chk(got, 8'h3C);
      $display("test address and data done");
      ack_en <= 1'b0;
      step(8'hA6, 8'h03, 8'h62);
      chk(got, 8'hA6);
      ack_en <= 1'b1;
      step(8'h00, 8'h05, 8'h28);
      chk(bus_busy, 1'b0);
      bus(1'b1, `OFS_STATE, 32'h0);
      @(posedge sys_clk);
      chk(irq_flag, 1'b0);
      $display("test repeated start and stop done");
      final_report;
   end
endmodule : twi_master_tb
